/* File: shs_pkg.sv */
// Package for the standby (halt / stop) controller: register map,
// reset values, wait-time codes, state encoding and gate bundle.
// Assumes one always-running controller clock equal to the system clock fx.
package shs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and register bus
   localparam int          CLK_HZ     = 25_000_000;
   localparam int          AW         = 3;
   localparam int          DW         = 8;
   localparam logic [2:0]  ADR_SETTLE = 3'h0;   // osc_settle_select
   localparam logic [2:0]  ADR_KRM    = 3'h1;   // key_return_pin_mode
   localparam logic [2:0]  ADR_STAT   = 3'h2;   // Sticky event status, W1C
   localparam logic [2:0]  ADR_MASK   = 3'h3;   // Event interrupt mask
   localparam logic [2:0]  ADR_STATE  = 3'h4;   // Controller state, read only

   ////////////////////////////////////////////////////////////////////////
   // Settle-time select codes and reset value
   localparam logic [2:0]  SETTLE_RST = 3'h4;
   localparam logic [2:0]  SEL_SHORT  = 3'h0;
   localparam logic [2:0]  SEL_MID    = 3'h2;
   localparam logic [2:0]  SEL_LONG   = 3'h4;
   localparam int          EXP_SHORT  = 12;     // 2^12 fx cycles
   localparam int          EXP_MID    = 15;     // 2^15 fx cycles
   localparam int          EXP_LONG   = 17;     // 2^17 fx cycles
   localparam int          CW         = 17;     // Wait counter width

   // Resume waits after a halt release, in clocks
   localparam int          VEC_WAIT_CLK  = 9;
   localparam int          NEXT_WAIT_CLK = 1;

   ////////////////////////////////////////////////////////////////////////
   // Event status bit positions
   localparam int          EV_HALT_REL  = 0;
   localparam int          EV_STOP_REL  = 1;
   localparam int          EV_STOP_FALL = 2;
   localparam int          EV_SE0_STOP  = 3;
   localparam int          NEV          = 4;

   typedef enum logic [2:0] {
      ST_RSTWAIT,
      ST_RUN,
      ST_HALT,
      ST_STOP,
      ST_STAB,
      ST_RESUME
   } shs_state_t;

   // Gate bundle towards CPU, oscillator, ports and peripherals
   typedef struct packed {
      logic cpu_clk_en;
      logic osc_en;
      logic osc_out_pullup;
      logic latch_hold;
      logic timer_zero_en;
      logic timer01_en;
      logic wdt_en;
      logic usb_full_en;
      logic serial_en;
   } shs_gate_t;

endpackage : shs_pkg

/* File: shs_standby_ctrl.sv */
// Standby controller: halt and stop entry, peripheral gating, release,
// settle wait, resume timing, register file and event interrupt.
// Assumes clk_i keeps running while the gated oscillator output is off,
// and that request, mask and command inputs come from clk_i logic.
//
// Overview of operation
// RULE_01: Halt stops the CPU clock but leaves the oscillator running.
// RULE_02: Halt holds port latches; timers, watchdog, USB and serial keep running.
// RULE_03: Key wake uses only mode-enabled pins; external requests act only unmasked.
// RULE_04: Unmasked request ends halt; vectored if enabled, else next instruction.
// RULE_05: Halt resume takes 9 to 10 clocks vectored, 1 to 2 otherwise.
// RULE_06: Non-maskable request ends halt always and is serviced vectored.
// RULE_07: Reset during halt ends it and restarts from the reset vector.
// RULE_08: Stop halts oscillator and CPU and holds port latches.
// RULE_09: Stop pulls the oscillator output pin up; not for external clocks.
// RULE_10: Pending unmasked request at stop gives halt, settle wait, then run.
// RULE_11: Stop disables timer zero and watchdog; timer one needs external input.
// RULE_12: In stop the USB function only reacts to reset or resume.
// RULE_13: In stop the serial interface works only with an external clock.
// RULE_14: Unmasked request ends stop; after settle wait, vectored or next instruction.
// RULE_15: Reset during stop ends it; reset processing follows the settle wait.
// RULE_16: Only unmasked requests and reset end stop, never the non-maskable one.
// RULE_17: Stop entered in single-ended zero ignores the USB reset/resume request.
// RULE_18: Software keeps the USB reset/resume flag set from suspend to stop.
// RULE_19: Settle select resets to 04H; codes 000, 010, 100 only.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module shs_standby_ctrl
   import shs_pkg::*;
#(
   parameter int N_IRQ       = 8,
   parameter int USB_IRQ_BIT = 0,
   parameter int N_KEY       = 4,
   parameter int WAIT_SHORT  = 2**EXP_SHORT,
   parameter int WAIT_MID    = 2**EXP_MID,
   parameter int WAIT_LONG   = 2**EXP_LONG
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 halt_exec_i,
   input  wire logic                 stop_exec_i,
   input  wire logic [N_IRQ-1:0]     irq_req_i,
   input  wire logic [N_IRQ-1:0]     irq_mask_flag_i,
   input  wire logic                 key_irq_mask_flag_i,
   input  wire logic                 global_irq_enable_i,
   input  wire logic                 nmi_req_i,
   input  wire logic [N_KEY-1:0]     key_pin_b_i,
   input  wire logic                 usb_minus_line_i,
   input  wire logic                 usb_plus_line_i,
   input  wire logic                 timer01_ext_count_input_sel_i,
   input  wire logic                 serial_ext_clk_sel_i,
   input  wire logic [shs_pkg::AW-1:0] reg_addr_i,
   input  wire logic [shs_pkg::DW-1:0] reg_wdata_i,
   input  wire logic                 reg_we_i,
   input  wire logic                 reg_re_i,
   output logic      [shs_pkg::DW-1:0] reg_rdata_o,
   output shs_pkg::shs_gate_t        gate_o,
   output logic                      cpu_reset_hold_o,
   output logic                      key_wake_o,
   output logic                      resume_o,
   output logic                      resume_vectored_o,
   output logic                      irq_o
);
   import shs_pkg::*;

   localparam int NS = N_KEY + 2;

   // Elaboration check of parameters
   if (USB_IRQ_BIT >= N_IRQ || N_KEY > DW || WAIT_SHORT < 1 ||
       WAIT_LONG > 2**CW) begin : g_bad
      $error("shs_standby_ctrl: unsupported parameter values");
   end

   // Maps a settle-select code to its wait in cycles, minus one
   function automatic logic [CW-1:0] settle_load(input logic [2:0] sel);
      logic [CW-1:0] v;
      v = CW'(WAIT_SHORT - 1);
      case (sel)
         SEL_MID:  v = CW'(WAIT_MID - 1);
         SEL_LONG: v = CW'(WAIT_LONG - 1);
         default:  v = CW'(WAIT_SHORT - 1);
      endcase
      return v;
   endfunction : settle_load

   // Gate settings that each state implies
   function automatic shs_gate_t gate_of(input shs_state_t s,
                                         input logic t01_ext,
                                         input logic ser_ext);
      shs_gate_t g;
      g = '0;
      g.cpu_clk_en     = (s == ST_RUN);
      g.osc_en         = (s != ST_STOP);
      g.osc_out_pullup = (s == ST_STOP);
      g.latch_hold     = (s == ST_HALT) || (s == ST_STOP) || (s == ST_STAB);
      g.timer_zero_en  = (s != ST_STOP);
      g.wdt_en         = (s != ST_STOP);
      g.timer01_en     = (s != ST_STOP) || t01_ext;
      g.usb_full_en    = (s != ST_STOP);
      g.serial_en      = (s != ST_STOP) || ser_ext;
      return g;
   endfunction : gate_of

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   logic [NS-1:0] s3_r;
   logic [NS-1:0] pin_r;
   wire  [NS-1:0] pin_raw = {usb_plus_line_i, usb_minus_line_i, key_pin_b_i};
   wire  [NS-1:0] agree   = ~(s2_r ^ s3_r);
   wire  [NS-1:0] pin_nxt = (agree & s3_r) | (~agree & pin_r);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r  <= '1;
         s2_r  <= '1;
         s3_r  <= '1;
         pin_r <= '1;
      end else begin
         s1_r  <= pin_raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= pin_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [2:0]       settle_r;
   logic [N_KEY-1:0] krm_r;
   logic [NEV-1:0]   stat_r;
   logic [NEV-1:0]   mask_r;
   shs_state_t       st_r;
   shs_state_t       st_nxt;
   logic [CW-1:0]    cnt_r;
   logic [CW-1:0]    cnt_nxt;
   logic             vec_r;
   logic             vec_nxt;
   logic             se0_r;
   logic [NEV-1:0]   ev_set;

   // Wake decoding
   wire [N_KEY-1:0] key_low  = ~pin_r[N_KEY-1:0];
   wire key_hit   = |(key_low & krm_r);                 // [RULE_03]
   wire se0_now   = ~pin_r[N_KEY] & ~pin_r[N_KEY+1];
   wire [N_IRQ-1:0] unmasked = irq_req_i & ~irq_mask_flag_i;  // [RULE_03]
   wire [N_IRQ-1:0] usb_only = N_IRQ'(1) << USB_IRQ_BIT;
   wire key_pend  = key_hit & ~key_irq_mask_flag_i;
   wire pending   = (|unmasked) | key_pend;
   // An SE0 entry blinds stop to the USB reset/resume source only
   wire stop_pend = (|(unmasked & ~(se0_r ? usb_only : '0))) | key_pend;  // [RULE_17]
   wire ie        = global_irq_enable_i;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;
      vec_nxt = vec_r;
      ev_set  = '0;
      case (st_r)
         ST_RSTWAIT: begin
            if (cnt_r == '0) st_nxt = ST_RUN;              // [RULE_07] [RULE_15]
         end
         ST_RUN: begin
            if (stop_exec_i && pending) begin
               st_nxt  = ST_STAB;                          // [RULE_10]
               cnt_nxt = settle_load(settle_r);
               vec_nxt = ie;
               ev_set[EV_STOP_FALL] = 1'b1;
            end else if (stop_exec_i) begin
               st_nxt  = ST_STOP;                          // [RULE_08]
               ev_set[EV_SE0_STOP] = se0_now;
            end else if (halt_exec_i) begin
               st_nxt  = ST_HALT;                          // [RULE_01]
            end
         end
         ST_HALT: begin
            if (nmi_req_i || pending) begin
               st_nxt  = ST_RESUME;                        // [RULE_04] [RULE_06]
               vec_nxt = nmi_req_i || ie;
               cnt_nxt = (nmi_req_i || ie) ? CW'(VEC_WAIT_CLK - 1)
                                           : CW'(NEXT_WAIT_CLK - 1);  // [RULE_05]
               ev_set[EV_HALT_REL] = 1'b1;
            end
         end
         ST_STOP: begin
            // Non-maskable requests are ignored here
            if (stop_pend) begin
               st_nxt  = ST_STAB;                          // [RULE_14] [RULE_16]
               cnt_nxt = settle_load(settle_r);
               vec_nxt = ie;
               ev_set[EV_STOP_REL] = 1'b1;
            end
         end
         ST_STAB: begin
            if (cnt_r == '0) st_nxt = ST_RUN;              // [RULE_14]
         end
         ST_RESUME: begin
            if (cnt_r == '0) st_nxt = ST_RUN;              // [RULE_05]
         end
         default: st_nxt = ST_RUN;
      endcase
   end

   // Reset always restarts through the 2^15 settle wait
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r  <= ST_RSTWAIT;                              // [RULE_07] [RULE_15]
         cnt_r <= CW'(WAIT_MID - 1);
         vec_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         vec_r <= vec_nxt;
      end
   end

   // SE0 condition caught at the stop entry, kept for the whole stop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) se0_r <= 1'b0;
      else if (st_r == ST_RUN && stop_exec_i) se0_r <= se0_now;  // [RULE_17]
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate and handshake outputs, registered from the next state
   wire resume_nxt = (st_nxt == ST_RUN) &&
                     (st_r == ST_RESUME || st_r == ST_STAB);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gate_o            <= gate_of(ST_RSTWAIT, 1'b0, 1'b0);
         cpu_reset_hold_o  <= 1'b1;
         resume_o          <= 1'b0;
         resume_vectored_o <= 1'b0;
      end else begin
         gate_o            <= gate_of(st_nxt, timer01_ext_count_input_sel_i,
                                      serial_ext_clk_sel_i);  // [RULE_02] [RULE_09] [RULE_11] [RULE_12] [RULE_13]
         cpu_reset_hold_o  <= (st_nxt == ST_RSTWAIT);
         resume_o          <= resume_nxt;
         resume_vectored_o <= resume_nxt && vec_nxt;
      end
   end

   assign key_wake_o = key_pend;

   ////////////////////////////////////////////////////////////////////////
   // Register file; bad settle codes are refused and the old code kept
   wire wr_settle = reg_we_i && reg_addr_i == ADR_SETTLE;
   wire wr_krm    = reg_we_i && reg_addr_i == ADR_KRM;
   wire wr_stat   = reg_we_i && reg_addr_i == ADR_STAT;
   wire wr_mask   = reg_we_i && reg_addr_i == ADR_MASK;
   wire [2:0] wsel = reg_wdata_i[2:0];
   wire sel_ok    = (wsel == SEL_SHORT) || (wsel == SEL_MID) || (wsel == SEL_LONG);
   wire [NEV-1:0] stat_clr = wr_stat ? reg_wdata_i[NEV-1:0] : '0;
   // Set wins over a same-cycle clear, so no event is lost
   wire [NEV-1:0] stat_nxt = (stat_r & ~stat_clr) | ev_set;
   logic [DW-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      case (reg_addr_i)
         ADR_SETTLE: rd_mux = DW'(settle_r);
         ADR_KRM:    rd_mux = DW'(krm_r);
         ADR_STAT:   rd_mux = DW'(stat_r);
         ADR_MASK:   rd_mux = DW'(mask_r);
         ADR_STATE:  rd_mux = DW'(st_r);
         default:    rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         settle_r    <= SETTLE_RST;                        // [RULE_19]
         krm_r       <= '0;
         stat_r      <= '0;
         mask_r      <= '0;
         reg_rdata_o <= '0;
      end else begin
         if (wr_settle && sel_ok) settle_r <= wsel;        // [RULE_19]
         if (wr_krm) krm_r <= reg_wdata_i[N_KEY-1:0];
         if (wr_mask) mask_r <= reg_wdata_i[NEV-1:0];
         stat_r      <= stat_nxt;
         reg_rdata_o <= reg_re_i ? rd_mux : '0;
      end
   end

   assign irq_o = |(stat_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence halt_vec_wake;
      st_r == ST_HALT && (nmi_req_i || (pending && ie));
   endsequence
   sequence halt_next_wake;
      st_r == ST_HALT && !nmi_req_i && pending && !ie;
   endsequence

   a_halt_cpu_off: assert property (st_r == ST_HALT |-> !gate_o.cpu_clk_en && gate_o.osc_en) // [RULE_01]
      else $error("halt: cpu clock on or oscillator off");
   a_halt_periph_on: assert property (st_r == ST_HALT |-> gate_o.latch_hold && gate_o.wdt_en
      && gate_o.timer_zero_en && gate_o.usb_full_en && gate_o.serial_en) // [RULE_02]
      else $error("halt: peripheral gated or latch released");
   a_masked_stays: assert property (st_r == ST_HALT && !pending && !nmi_req_i
      |=> st_r == ST_HALT) // [RULE_04]
      else $error("halt left without a wake source");
   a_halt_vec_wait: assert property (halt_vec_wake |=> !gate_o.cpu_clk_en [*8]
      ##2 gate_o.cpu_clk_en && resume_vectored_o) // [RULE_05] [RULE_06]
      else $error("vectored halt resume timing wrong");
   a_halt_next_wait: assert property (halt_next_wake |=> !gate_o.cpu_clk_en
      ##1 gate_o.cpu_clk_en && resume_o && !resume_vectored_o) // [RULE_05]
      else $error("non-vectored halt resume timing wrong");
   a_stop_osc_off: assert property (st_r == ST_STOP |-> !gate_o.osc_en
      && gate_o.osc_out_pullup && gate_o.latch_hold && !gate_o.cpu_clk_en) // [RULE_08]
      else $error("stop: oscillator, pull-up or latch wrong");
   a_stop_pend_halt: assert property (st_r == ST_RUN && stop_exec_i && pending
      |=> st_r == ST_STAB && gate_o.osc_en) // [RULE_10]
      else $error("pending request did not divert stop");
   a_stop_gating: assert property (st_r == ST_STOP && $past(st_r) == ST_STOP
      |-> !gate_o.timer_zero_en && !gate_o.wdt_en
      && gate_o.timer01_en == $past(timer01_ext_count_input_sel_i)
      && gate_o.serial_en == $past(serial_ext_clk_sel_i) && !gate_o.usb_full_en) // [RULE_11]
      else $error("stop peripheral gating wrong");
   a_stop_no_nmi: assert property (st_r == ST_STOP && !stop_pend |=> st_r == ST_STOP) // [RULE_16]
      else $error("stop left without unmasked request");
   a_se0_blind: assert property (st_r == ST_STOP && se0_r && !key_pend
      && unmasked == usb_only |=> st_r == ST_STOP) // [RULE_17]
      else $error("usb request released an SE0 stop");
   a_settle_reset: assert property ($rose(rst_b_i) |-> settle_r == SETTLE_RST
      && cpu_reset_hold_o) // [RULE_19]
      else $error("settle select or reset hold wrong after reset");

endmodule : shs_standby_ctrl

/* File: shs_cpu_model.sv */
// Model of the CPU core and the interrupt sources facing the standby controller.
// Assumes the bench clock; commands are issued only while the CPU clock runs.
`timescale 1ns/1ps
module shs_cpu_model (
   input  wire logic       clk_i,
   output logic            halt_exec_o,
   output logic            stop_exec_o,
   output logic [7:0]      irq_req_o,
   output logic [7:0]      irq_mask_o,
   output logic            ie_o,
   output logic            nmi_o
);
   ////////////////////////////////////////////////////////////////////////
   // Idle levels: no request, every source masked, interrupts disabled
   initial begin
      halt_exec_o = 1'b0;
      stop_exec_o = 1'b0;
      irq_req_o   = 8'h00;
      irq_mask_o  = 8'hFF;
      ie_o        = 1'b0;
      nmi_o       = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // A standby instruction is a one-cycle pulse; the system clock is a
   // crystal here, so stop is never used with an external clock
   task automatic cmd(input logic stop);
      @(posedge clk_i);
      if (stop) begin
         stop_exec_o <= 1'b1;
      end else begin
         halt_exec_o <= 1'b1;
      end
      @(posedge clk_i);
      stop_exec_o <= 1'b0;
      halt_exec_o <= 1'b0;
   endtask : cmd

   // Request flags are levels that stay set until software clears them,
   // so a pending flag is never lost between detection and stop
   task automatic lev(input logic [7:0] req, input logic [7:0] msk,
                      input logic ie, input logic nmi);
      @(posedge clk_i);
      irq_req_o  <= req;
      irq_mask_o <= msk;
      ie_o       <= ie;
      nmi_o      <= nmi;
   endtask : lev
endmodule : shs_cpu_model

/* File: tb.sv */
// Self-checking bench for the standby controller: reset, registers, halt and
// stop entry and release, settle waits, key wake and the event interrupt.
// Assumes shs_pkg, shs_standby_ctrl and shs_cpu_model are compiled first.
`timescale 1ns/1ps
module tb;
   import shs_pkg::*;
   localparam int WS = 4;
   localparam int WM = 8;
   localparam int WL = 16;
   typedef struct packed {
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } shs_row_t;

   logic            clk = 1'b0;
   logic            rst_b = 1'b0;
   logic [3:0]      key_pin_b = 4'hF;
   logic            usb_m = 1'b0;
   logic            usb_p = 1'b1;
   logic            t01_sel = 1'b0;
   logic            ser_sel = 1'b0;
   logic            key_mask = 1'b1;
   logic [2:0]      reg_addr = 3'h0;
   logic [7:0]      reg_wdata = 8'h00;
   logic            reg_we = 1'b0;
   logic            reg_re = 1'b0;
   logic [7:0]      rdata;
   shs_gate_t       gate;
   logic            hold, key_wake, resume, res_vec, irq;
   logic            halt_x, stop_x, ie, nmi;
   logic [7:0]      irq_req, irq_mask;
   int              err_total = 0;
   int              compares = 0;
   logic [2:0]      sc [3] = '{SEL_SHORT, SEL_MID, SEL_LONG};
   int              wt [3] = '{WS, WM, WL};
   shs_row_t        rows [10] = '{'{ADR_SETTLE, 8'h00, 8'h00}, '{ADR_SETTLE, 8'h03, 8'h00},
      '{ADR_SETTLE, 8'h02, 8'h02}, '{ADR_SETTLE, 8'h07, 8'h02}, '{ADR_SETTLE, 8'h04, 8'h04},
      '{ADR_KRM, 8'h05, 8'h05}, '{ADR_STATE, 8'h00, 8'h01}, '{3'h5, 8'hFF, 8'h00},
      '{ADR_MASK, 8'h0F, 8'h0F}, '{ADR_MASK, 8'h00, 8'h00}};

   ////////////////////////////////////////////////////////////////////////
   // Clock, design and CPU model; short waits keep the run brief
   always #20 clk = ~clk;

   shs_standby_ctrl #(.WAIT_SHORT(WS), .WAIT_MID(WM), .WAIT_LONG(WL)) DUT (
      .clk_i(clk), .rst_b_i(rst_b), .halt_exec_i(halt_x), .stop_exec_i(stop_x),
      .irq_req_i(irq_req), .irq_mask_flag_i(irq_mask), .key_irq_mask_flag_i(key_mask),
      .global_irq_enable_i(ie), .nmi_req_i(nmi), .key_pin_b_i(key_pin_b),
      .usb_minus_line_i(usb_m), .usb_plus_line_i(usb_p),
      .timer01_ext_count_input_sel_i(t01_sel), .serial_ext_clk_sel_i(ser_sel),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
      .reg_rdata_o(rdata), .gate_o(gate), .cpu_reset_hold_o(hold), .key_wake_o(key_wake),
      .resume_o(resume), .resume_vectored_o(res_vec), .irq_o(irq));

   shs_cpu_model cpu (.clk_i(clk), .halt_exec_o(halt_x), .stop_exec_o(stop_x),
      .irq_req_o(irq_req), .irq_mask_o(irq_mask), .ie_o(ie), .nmi_o(nmi));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, bus cycles and shared sequences
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e}, "register read");
   endtask : rd

   // Reset for 6 cycles, then the settle: hold falls WAIT_MID edges after release
   task automatic do_reset();
      int n;
      n = 0;
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk({6'h00, hold, gate}, 16'h029F, "gates in reset");
      while (hold !== 1'b0 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(n), 16'(WM), "post-reset settle");
      chk({7'h00, gate}, 16'h019F, "run gates");
   endtask : do_reset

   // Bounded wait for the resume pulse; latency counted in clock edges from the call
   task automatic wait_res(input int n_exp, input logic v_exp);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (resume !== 1'b1 && n < 300);
      chk(16'(n), 16'(n_exp), "resume latency");
      chk({15'h0000, res_vec}, {15'h0000, v_exp}, "resume kind");
   endtask : wait_res

   task automatic halt_rel(input logic [7:0] req, input logic e, input logic m,
                           input int n, input logic v);
      cpu.cmd(1'b0);
      cpu.lev(req, 8'h00, e, m);
      wait_res(n, v);
      cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
   endtask : halt_rel

   task automatic tend(input string s);
      $display("end of test: %s", s);
   endtask : tend

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: table of register cases, then the standby scenarios
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      tend("registers");
      wr(ADR_STAT, 8'h0F);
      cpu.cmd(1'b0);
      cpu.lev(8'h01, 8'h01, 1'b1, 1'b0);
      repeat (20) @(posedge clk);
      #1 chk({7'h00, gate}, 16'h00BF, "halt held, masked");
      cpu.lev(8'h01, 8'h00, 1'b1, 1'b0);
      wait_res(10, 1'b1);
      cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
      rd(ADR_STAT, 8'h01);
      wr(ADR_MASK, 8'h01);
      #1 chk({15'h0000, irq}, 16'h0001, "event irq");
      wr(ADR_STAT, 8'h01);
      #1 chk({15'h0000, irq}, 16'h0000, "event irq cleared");
      wr(ADR_MASK, 8'h00);
      halt_rel(8'h01, 1'b0, 1'b0, 2, 1'b0);
      halt_rel(8'h00, 1'b0, 1'b1, 10, 1'b1);
      cpu.cmd(1'b0);
      repeat (3) @(posedge clk);
      do_reset();
      tend("halt");
      for (int i = 0; i < 3; i++) begin
         wr(ADR_SETTLE, {5'h00, sc[i]});
         @(posedge clk);
         t01_sel <= i[0];
         ser_sel <= ~i[0];
         cpu.cmd(1'b1);
         repeat (2) @(posedge clk);
         #1 chk({7'h00, gate}, {7'h00, 4'h3, 1'h0, t01_sel, 2'h0, ser_sel},
                "stop gates");
         cpu.lev(8'h01, 8'h00, i[0], 1'b0);
         wait_res(wt[i] + 1, i[0]);
         cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
      end
      cpu.cmd(1'b1);
      cpu.lev(8'h01, 8'h01, 1'b1, 1'b1);
      repeat (30) @(posedge clk);
      #1 chk({15'h0000, gate.osc_en}, 16'h0000, "stop kept");
      cpu.lev(8'h01, 8'h00, 1'b1, 1'b1);
      wait_res(WL + 1, 1'b1);
      cpu.lev(8'h02, 8'h00, 1'b0, 1'b0);
      cpu.cmd(1'b1);
      @(posedge clk);
      #1 chk({14'h0000, gate.cpu_clk_en, gate.osc_en}, 16'h0001, "pending stop");
      wait_res(WL - 1, 1'b0);
      cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
      usb_p <= 1'b0;
      wr(ADR_STAT, 8'h0F);
      repeat (5) @(posedge clk);
      cpu.cmd(1'b1);
      cpu.lev(8'h01, 8'h00, 1'b1, 1'b0);
      repeat (30) @(posedge clk);
      rd(ADR_STAT, 8'h08);
      cpu.lev(8'h03, 8'h00, 1'b1, 1'b0);
      wait_res(WL + 1, 1'b1);
      cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
      usb_m <= 1'b1;
      cpu.cmd(1'b1);
      repeat (3) @(posedge clk);
      do_reset();
      rd(ADR_SETTLE, 8'h04);
      // Minus line high, plus low is no SE0: the USB request releases stop
      cpu.cmd(1'b1);
      cpu.lev(8'h01, 8'h00, 1'b0, 1'b0);
      wait_res(WL + 1, 1'b0);
      cpu.lev(8'h00, 8'h00, 1'b0, 1'b0);
      tend("stop");
      wr(ADR_KRM, 8'h05);
      key_mask <= 1'b0;
      key_pin_b <= 4'hD;
      repeat (10) @(posedge clk);
      #1 chk({15'h0000, key_wake}, 16'h0000, "key pin not enabled");
      key_pin_b <= 4'hB;
      repeat (10) @(posedge clk);
      #1 chk({15'h0000, key_wake}, 16'h0001, "key pin enabled");
      key_mask <= 1'b1;
      @(posedge clk);
      #1 chk({15'h0000, key_wake}, 16'h0000, "key masked");
      tend("key return");
      give_verdict();
   end

   // Watchdog: the sequence needs roughly four hundred cycles; the limit is 20000 cycles
   initial begin
      #(40 * 20000);
      err_total++;
      give_verdict();
   end
endmodule : tb
